// ### logic/qsm_pkg.sv
// Constants, register map and helpers for the quad system interface multiplexer
// Behaviour
// - Multiplex enable carries all four E1 frames on one 8.192/16.384 Mbit/s stream
// - In multiplex mode channel 1 clock and sync time all four channels
// - Clock rate code 10 is 8.192 MHz; data rate hi=1 lo=0 is 8.192 Mbit/s
// - Channel outputs are ORed; each channel gets a distinct phase 000 to 011
// - Interleave select 0 interleaves by byte, time slot by time slot
// - Interleave select 1 interleaves by bit, framers 1 to 4 per bit
// - Channels 2 to 4 outputs undefined, their clocks, syncs and inputs ignored
// - Shared port codes: timer input, timer output, frame clock high, frame clock low
// - Frame clock only while the selected channel's clock synthesizer is active
// - Source select picks channel 1 to 4 for the shared port
// - Select routes channel 1 to 4 receive clock to first receive clock output
// - Receive system and route clock ports input at 0, output at 1
// - Transmit system clock direction 0 makes that port an input
// - Transmit multiframe sync active low at polarity 0, high at 1
package qsm_pkg;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h84;
  localparam logic [7:0] ADDR_GLOBAL = 8'h85;
  localparam logic [7:0] ADDR_SYS_IF = 8'h86;
  localparam logic [7:0] ADDR_RX_OFS = 8'h87;
  localparam logic [7:0] ADDR_TX_OFS = 8'h88;
  localparam logic [7:0] ADDR_CH_BASE = 8'h90;
  localparam logic [7:0] ADDR_CH_LAST = 8'h93;
  localparam logic [7:0] ADDR_STATUS = 8'h94;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Port direction register fields
  localparam int PD_RCLK = 0;
  localparam int PD_RX_SYS = 1;
  localparam int PD_TX_SYS = 2;
  localparam int PD_MF_POL = 3;
  localparam logic [7:0] PD_MASK = 8'h0F;
  // Global register fields
  localparam int GL_RX1 = 0;
  localparam int GL_SRC = 2;
  localparam int GL_SHARED = 4;
  localparam int GL_MUX = 6;
  localparam logic [7:0] GL_MASK = 8'h7F;
  // System interface register fields
  localparam int SI_RATE = 0;
  localparam int SI_DR_HI = 2;
  localparam int SI_DR_LO = 3;
  localparam int SI_BIM = 4;
  localparam int SI_TX_MF = 5;
  localparam logic [7:0] SI_MASK = 8'h3F;
  // Per-channel register fields
  localparam int CH_PHASE = 0;
  localparam int CH_SYNTH = 3;
  localparam int CH_RS = 4;
  localparam logic [7:0] CH_MASK = 8'h3F;
  // Codes
  localparam logic [1:0] CLK_RATE_8M = 2'h2;
  localparam logic [1:0] CLK_RATE_16M = 2'h3;
  localparam logic [1:0] SHARED_SEC_IN = 2'h0;
  localparam logic [1:0] SHARED_SEC_OUT = 2'h1;
  localparam logic [1:0] SHARED_FSC_HI = 2'h2;
  localparam logic [1:0] SHARED_FSC_LO = 2'h3;
  localparam logic [1:0] RS_SYNTH_A = 2'h2;
  localparam logic [1:0] RS_SYNTH_B = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [10:0] POS_LAST_SLOW = 11'h3FF;
  localparam logic [10:0] POS_LAST_FAST = 11'h7FF;
  localparam int POS_IDLE = 10;

  // Channel that owns a stream position
  function automatic logic [1:0] pos_chan(input logic [10:0] pos, input logic interleave_select);
    return interleave_select ? pos[1:0] : pos[4:3];
  endfunction

  // Bit index within the byte, 0 is sent first
  function automatic logic [2:0] pos_bit(input logic [10:0] pos, input logic interleave_select);
    return interleave_select ? pos[4:2] : pos[2:0];
  endfunction

  function automatic logic [4:0] pos_slot(input logic [10:0] pos);
    return pos[9:5];
  endfunction

  function automatic logic [10:0] pos_next(input logic [10:0] pos, input logic [10:0] last);
    return (pos == last) ? 11'h000 : pos + 11'h001;
  endfunction

  function automatic logic synth_active(input logic [7:0] cfg);
    return cfg[CH_SYNTH] | (cfg[CH_RS +: 2] == RS_SYNTH_A) | (cfg[CH_RS +: 2] == RS_SYNTH_B);
  endfunction
endpackage

// ### logic/qsm_sync3.sv
// Three-stage pin sampler with agreement filter and edge pulses
`timescale 1ns/1ps
module qsm_sync3 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Sampling chain
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= (s2_r == s3_r) && s3_r && !o_level;
      o_fall <= (s2_r == s3_r) && !s3_r && o_level;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end
endmodule

// ### logic/qsm_chan_lane.sv
// One channel's slice of the shared stream, receive drive and transmit capture
`timescale 1ns/1ps
module qsm_chan_lane (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_phase,
  input wire logic i_rx_live,
  input wire logic [1:0] i_rx_chan,
  input wire logic [2:0] i_rx_bit,
  input wire logic [7:0] i_rx_byte,
  input wire logic [7:0] i_rx_sig_byte,
  input wire logic i_tx_take,
  input wire logic [1:0] i_tx_chan,
  input wire logic [2:0] i_tx_bit,
  input wire logic i_tx_data,
  input wire logic i_tx_sig,
  output logic o_rx_data,
  output logic o_rx_sig,
  output logic [7:0] o_tx_byte,
  output logic [7:0] o_tx_sig_byte,
  output logic o_tx_valid
);
  logic rx_sel;
  logic tx_sel;
  logic [2:0] rx_idx;
  logic [6:0] tx_sh_r;
  logic [6:0] sig_sh_r;

  // Only phases 000 to 011 ever match a stream slot
  assign rx_sel = i_rx_live && (i_phase == {1'b0, i_rx_chan});
  assign tx_sel = i_tx_take && (i_phase == {1'b0, i_tx_chan});
  assign rx_idx = qsm_pkg::BIT_LAST - i_rx_bit;

  // First bit of a slot is the byte's MSB; zero outside our phase
  assign o_rx_data = rx_sel & i_rx_byte[rx_idx];
  assign o_rx_sig = rx_sel & i_rx_sig_byte[rx_idx];

  // Transmit capture, byte handed over with the last bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_sh_r <= 7'h00;
      sig_sh_r <= 7'h00;
      o_tx_byte <= 8'h00;
      o_tx_sig_byte <= 8'h00;
      o_tx_valid <= 1'b0;
    end else begin
      o_tx_valid <= 1'b0;
      if (tx_sel) begin
        tx_sh_r <= {tx_sh_r[5:0], i_tx_data};
        sig_sh_r <= {sig_sh_r[5:0], i_tx_sig};
        if (i_tx_bit == qsm_pkg::BIT_LAST) begin
          o_tx_byte <= {tx_sh_r, i_tx_data};
          o_tx_sig_byte <= {sig_sh_r, i_tx_sig};
          o_tx_valid <= 1'b1;
        end
      end
    end
  end

  a_lane_valid: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid |-> $past(tx_sel) && ($past(i_tx_bit) == qsm_pkg::BIT_LAST))
    else $error("byte handed over without last bit of own phase");
  a_lane_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_phase[2] || !i_rx_live) |-> !o_rx_data && !o_rx_sig)
    else $error("lane drives the OR outside its phase");
endmodule

// ### logic/qsm_sys_mux.sv
// Global system interface multiplexer, shared port and clock routing
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module qsm_sys_mux (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic i_rx_sys_clk,
  input wire logic i_rx_sync_pulse,
  input wire logic i_tx_sys_clk,
  input wire logic i_tx_sync_pulse,
  input wire logic i_tx_multiframe_sync,
  input wire logic i_tx_data_in,
  input wire logic i_tx_sig_in,
  input wire logic [3:0][7:0] i_rx_byte,
  input wire logic [3:0][7:0] i_rx_sig_byte,
  output logic [4:0] o_rx_slot,
  output logic o_rx_data_out,
  output logic o_rx_sig_out,
  output logic [3:0][7:0] o_tx_byte,
  output logic [3:0][7:0] o_tx_sig_byte,
  output logic [3:0] o_tx_valid,
  output logic [4:0] o_tx_slot,
  input wire logic [3:0] i_ch_frame_clk,
  input wire logic [3:0] i_ch_sec_timer,
  input wire logic i_shared_port_in,
  output logic o_shared_port_out,
  output logic o_shared_port_oe_n,
  output logic o_sec_timer_in,
  input wire logic [3:0] i_ch_rx_clk,
  output logic o_rx_clk1,
  output logic [2:0] o_rx_clk_rest,
  output logic o_rx_sys_clk_oe_n,
  output logic o_tx_sys_clk_oe_n,
  output logic o_rx_route_clk_oe_n
);
  logic [7:0] port_dir_r;
  logic [7:0] global_r;
  logic [7:0] sys_if_r;
  logic [7:0] rx_ofs_r;
  logic [7:0] tx_ofs_r;
  logic [3:0][7:0] ch_cfg_r;
  logic rx_seen_r;
  logic tx_seen_r;
  logic [10:0] rx_pos_r;
  logic [10:0] tx_pos_r;
  logic rx_div_r;
  logic tx_div_r;
  logic rx_clk_rise, rx_sp_rise;
  logic tx_clk_rise, tx_sp_rise;
  logic mf_rise, mf_fall;
  logic tx_d_lvl, tx_s_lvl, sh_in_lvl;
  logic mux_on, interleave_select, slow_clk, fast_data, need_div;
  logic rx_adv, tx_adv, tx_sync_evt;
  logic [10:0] pos_last;
  logic [3:0] lane_rx, lane_sig;
  logic [1:0] shared_mode, shared_src;
  logic [7:0] src_cfg;

  assign mux_on = global_r[qsm_pkg::GL_MUX];
  assign interleave_select = sys_if_r[qsm_pkg::SI_BIM];
  // 16.384 MHz clock with 8.192 Mbit/s data advances every other edge
  assign slow_clk = sys_if_r[qsm_pkg::SI_RATE +: 2] == qsm_pkg::CLK_RATE_8M;
  assign fast_data = sys_if_r[qsm_pkg::SI_DR_HI] & sys_if_r[qsm_pkg::SI_DR_LO];
  assign need_div = !slow_clk && !fast_data;
  assign pos_last = fast_data ? qsm_pkg::POS_LAST_FAST : qsm_pkg::POS_LAST_SLOW;
  assign shared_mode = global_r[qsm_pkg::GL_SHARED +: 2];
  assign shared_src = global_r[qsm_pkg::GL_SRC +: 2];
  assign src_cfg = ch_cfg_r[shared_src];

  // Pin samplers; only channel 1 timing pins exist in this mode
  qsm_sync3 u_rx_clk (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_rx_sys_clk),
    .o_level(), .o_rise(rx_clk_rise), .o_fall());
  qsm_sync3 u_rx_sp (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_rx_sync_pulse),
    .o_level(), .o_rise(rx_sp_rise), .o_fall());
  qsm_sync3 u_tx_clk (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tx_sys_clk),
    .o_level(), .o_rise(tx_clk_rise), .o_fall());
  qsm_sync3 u_tx_sp (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tx_sync_pulse),
    .o_level(), .o_rise(tx_sp_rise), .o_fall());
  qsm_sync3 u_tx_mf (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tx_multiframe_sync),
    .o_level(), .o_rise(mf_rise), .o_fall(mf_fall));
  qsm_sync3 u_tx_d (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tx_data_in),
    .o_level(tx_d_lvl), .o_rise(), .o_fall());
  qsm_sync3 u_tx_s (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tx_sig_in),
    .o_level(tx_s_lvl), .o_rise(), .o_fall());
  qsm_sync3 u_sh_in (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_shared_port_in),
    .o_level(sh_in_lvl), .o_rise(), .o_fall());

  // Multiframe sync begins the frame on its active edge
  assign tx_sync_evt = sys_if_r[qsm_pkg::SI_TX_MF] ?
    (port_dir_r[qsm_pkg::PD_MF_POL] ? mf_rise : mf_fall) : tx_sp_rise;
  assign rx_adv = rx_clk_rise && !(need_div && rx_div_r);
  assign tx_adv = tx_clk_rise && !(need_div && tx_div_r);

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port_dir_r <= qsm_pkg::RESET_VAL;
      global_r <= qsm_pkg::RESET_VAL;
      sys_if_r <= qsm_pkg::RESET_VAL;
      rx_ofs_r <= qsm_pkg::RESET_VAL;
      tx_ofs_r <= qsm_pkg::RESET_VAL;
      ch_cfg_r <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        qsm_pkg::ADDR_PORT_DIR: port_dir_r <= i_wr_data & qsm_pkg::PD_MASK;
        qsm_pkg::ADDR_GLOBAL: global_r <= i_wr_data & qsm_pkg::GL_MASK;
        qsm_pkg::ADDR_SYS_IF: sys_if_r <= i_wr_data & qsm_pkg::SI_MASK;
        qsm_pkg::ADDR_RX_OFS: rx_ofs_r <= i_wr_data;
        qsm_pkg::ADDR_TX_OFS: tx_ofs_r <= i_wr_data;
        default: begin
          if (i_addr >= qsm_pkg::ADDR_CH_BASE && i_addr <= qsm_pkg::ADDR_CH_LAST) begin
            ch_cfg_r[i_addr[1:0]] <= i_wr_data & qsm_pkg::CH_MASK;
          end
        end
      endcase
    end
  end

  // Read data one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (!i_rd) begin
      o_rd_data <= 8'h00;
    end else begin
      unique case (i_addr)
        qsm_pkg::ADDR_PORT_DIR: o_rd_data <= port_dir_r;
        qsm_pkg::ADDR_GLOBAL: o_rd_data <= global_r;
        qsm_pkg::ADDR_SYS_IF: o_rd_data <= sys_if_r;
        qsm_pkg::ADDR_RX_OFS: o_rd_data <= rx_ofs_r;
        qsm_pkg::ADDR_TX_OFS: o_rd_data <= tx_ofs_r;
        qsm_pkg::ADDR_STATUS: o_rd_data <= {1'b0, qsm_pkg::pos_slot(rx_pos_r), tx_seen_r,
          rx_seen_r};
        default: begin
          if (i_addr >= qsm_pkg::ADDR_CH_BASE && i_addr <= qsm_pkg::ADDR_CH_LAST) begin
            o_rd_data <= ch_cfg_r[i_addr[1:0]];
          end else begin
            o_rd_data <= 8'h00;
          end
        end
      endcase
    end
  end

  // Receive stream position, restarted at the offset by the sync pulse
  always_ff @(posedge i_clk) begin
    if (i_rst || !mux_on) begin
      rx_pos_r <= 11'h000;
      rx_div_r <= 1'b0;
      rx_seen_r <= 1'b0;
    end else if (rx_sp_rise) begin
      rx_pos_r <= {1'b0, rx_ofs_r, 2'b00};
      rx_div_r <= 1'b0;
      rx_seen_r <= 1'b1;
    end else if (rx_clk_rise) begin
      rx_div_r <= need_div ? !rx_div_r : 1'b0;
      if (rx_adv) begin
        rx_pos_r <= qsm_pkg::pos_next(rx_pos_r, pos_last);
      end
    end
  end

  // Transmit stream position
  always_ff @(posedge i_clk) begin
    if (i_rst || !mux_on) begin
      tx_pos_r <= 11'h000;
      tx_div_r <= 1'b0;
      tx_seen_r <= 1'b0;
    end else if (tx_sync_evt) begin
      tx_pos_r <= {1'b0, tx_ofs_r, 2'b00};
      tx_div_r <= 1'b0;
      tx_seen_r <= 1'b1;
    end else if (tx_clk_rise) begin
      tx_div_r <= need_div ? !tx_div_r : 1'b0;
      if (tx_adv) begin
        tx_pos_r <= qsm_pkg::pos_next(tx_pos_r, pos_last);
      end
    end
  end

  // Four lanes share the positions; the upper half of a 16.384 stream is idle
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      qsm_chan_lane u_lane (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_phase(ch_cfg_r[g][qsm_pkg::CH_PHASE +: 3]),
        .i_rx_live(mux_on && !rx_pos_r[qsm_pkg::POS_IDLE]),
        .i_rx_chan(qsm_pkg::pos_chan(rx_pos_r, interleave_select)),
        .i_rx_bit(qsm_pkg::pos_bit(rx_pos_r, interleave_select)),
        .i_rx_byte(i_rx_byte[g]),
        .i_rx_sig_byte(i_rx_sig_byte[g]),
        .i_tx_take(mux_on && tx_adv && !tx_pos_r[qsm_pkg::POS_IDLE]),
        .i_tx_chan(qsm_pkg::pos_chan(tx_pos_r, interleave_select)),
        .i_tx_bit(qsm_pkg::pos_bit(tx_pos_r, interleave_select)),
        .i_tx_data(tx_d_lvl),
        .i_tx_sig(tx_s_lvl),
        .o_rx_data(lane_rx[g]),
        .o_rx_sig(lane_sig[g]),
        .o_tx_byte(o_tx_byte[g]),
        .o_tx_sig_byte(o_tx_sig_byte[g]),
        .o_tx_valid(o_tx_valid[g])
      );
    end
  endgenerate

  // Receive outputs: OR of the lanes, channel 1 pins only
  always_ff @(posedge i_clk) begin
    if (i_rst || !mux_on) begin
      o_rx_data_out <= 1'b0;
      o_rx_sig_out <= 1'b0;
      o_rx_slot <= 5'h00;
    end else begin
      o_rx_slot <= qsm_pkg::pos_slot(rx_pos_r);
      if (rx_adv) begin
        o_rx_data_out <= |lane_rx;
        o_rx_sig_out <= |lane_sig;
      end
    end
  end

  // Slot of the byte being handed to the framers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_slot <= 5'h00;
    end else if (tx_adv) begin
      o_tx_slot <= qsm_pkg::pos_slot(tx_pos_r);
    end
  end

  // Shared one-second / frame clock port
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_shared_port_out <= 1'b0;
      o_shared_port_oe_n <= 1'b1;
      o_sec_timer_in <= 1'b0;
    end else begin
      o_shared_port_oe_n <= shared_mode == qsm_pkg::SHARED_SEC_IN;
      o_sec_timer_in <= (shared_mode == qsm_pkg::SHARED_SEC_IN) && sh_in_lvl;
      unique case (shared_mode)
        qsm_pkg::SHARED_SEC_IN: o_shared_port_out <= 1'b0;
        qsm_pkg::SHARED_SEC_OUT: o_shared_port_out <= i_ch_sec_timer[shared_src];
        qsm_pkg::SHARED_FSC_HI: o_shared_port_out <=
          i_ch_frame_clk[shared_src] && qsm_pkg::synth_active(src_cfg);
        qsm_pkg::SHARED_FSC_LO: o_shared_port_out <=
          !(i_ch_frame_clk[shared_src] && qsm_pkg::synth_active(src_cfg));
      endcase
    end
  end

  // Receive clock routing and clock port directions
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_clk1 <= 1'b0;
      o_rx_clk_rest <= 3'h0;
      o_rx_sys_clk_oe_n <= 1'b1;
      o_tx_sys_clk_oe_n <= 1'b1;
      o_rx_route_clk_oe_n <= 1'b1;
    end else begin
      o_rx_clk1 <= i_ch_rx_clk[global_r[qsm_pkg::GL_RX1 +: 2]];
      o_rx_clk_rest <= i_ch_rx_clk[3:1];
      o_rx_sys_clk_oe_n <= !port_dir_r[qsm_pkg::PD_RX_SYS];
      o_tx_sys_clk_oe_n <= !port_dir_r[qsm_pkg::PD_TX_SYS];
      o_rx_route_clk_oe_n <= !port_dir_r[qsm_pkg::PD_RCLK];
    end
  end

  a_mux_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    !mux_on ##1 !mux_on |-> !o_rx_data_out && !o_rx_sig_out)
    else $error("stream active while multiplex disabled");
  a_rx_sync_start: assert property (@(posedge i_clk) disable iff (i_rst)
    mux_on && rx_sp_rise ##1 mux_on |-> rx_pos_r == {1'b0, $past(rx_ofs_r), 2'b00})
    else $error("receive sync did not restart position at offset");
  a_tx_pol: assert property (@(posedge i_clk) disable iff (i_rst)
    mux_on && sys_if_r[qsm_pkg::SI_TX_MF] && !port_dir_r[qsm_pkg::PD_MF_POL] && mf_fall
    ##1 mux_on |-> tx_pos_r == {1'b0, $past(tx_ofs_r), 2'b00})
    else $error("active-low multiframe sync not honoured");
  a_rd_global: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr == qsm_pkg::ADDR_GLOBAL && !i_wr |=> o_rd_data == $past(global_r))
    else $error("global register read back wrong");
  a_fsc_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    shared_mode == qsm_pkg::SHARED_FSC_HI && !qsm_pkg::synth_active(src_cfg)
    ##1 $stable(global_r) && $stable(src_cfg) |-> !o_shared_port_out)
    else $error("frame clock out while synthesizer inactive");
  a_sec_dir: assert property (@(posedge i_clk) disable iff (i_rst)
    $stable(shared_mode) && shared_mode == qsm_pkg::SHARED_SEC_IN |=>
    o_shared_port_oe_n && !o_shared_port_out)
    else $error("shared port driven in timer input mode");
  a_rclk_route: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_rx_clk1 == $past(i_ch_rx_clk[global_r[qsm_pkg::GL_RX1 +: 2]]))
    else $error("first receive clock not from selected channel");
  a_tx_dir: assert property (@(posedge i_clk) disable iff (i_rst)
    !port_dir_r[qsm_pkg::PD_TX_SYS] [*2] |-> o_tx_sys_clk_oe_n)
    else $error("transmit system clock driven while configured input");
  a_byte_order: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid[0] && !interleave_select |-> $past(qsm_pkg::pos_chan(tx_pos_r, 1'b0)) == 2'h0 ||
    ch_cfg_r[0][qsm_pkg::CH_PHASE +: 3] != 3'h0)
    else $error("byte-interleaved capture out of order");
endmodule

// ### test/qsm_far_end.sv
// Backplane highway model: link clock, frame sync and serial transmit stream
`timescale 1ns/1ps
module qsm_far_end (
  output logic o_link_clk,
  output logic o_sync,
  output logic o_data,
  output logic o_sig,
  input wire logic i_data,
  input wire logic i_sig
);
  // Idle highway: clock stands still between frames
  initial begin
    o_link_clk = 1'b0;
    o_sync = 1'b0;
    o_data = 1'b0;
    o_sig = 1'b0;
  end

  // One 32-position frame; lines change mid-period so each rising edge sees settled data
  task automatic frame(input logic [31:0] d, input logic [31:0] s,
                       output logic [31:0] rd, output logic [31:0] rs);
    #7;
    o_sync = 1'b1;
    for (int k = 0; k <= 32; k++) begin
      if (k < 32) begin
        o_data = d[k];
        o_sig = s[k];
      end else begin
        // Released lines show the inverse of their last value
        o_data = ~o_data;
        o_sig = ~o_sig;
      end
      #80;
      if (k > 0) begin
        rd[k - 1] = i_data;
        rs[k - 1] = i_sig;
      end
      if (k < 32) begin
        o_link_clk = 1'b1;
        #80;
        o_link_clk = 1'b0;
        o_sync = 1'b0;
      end
    end
  endtask
endmodule

// ### test/test_qsm_sys_mux.sv
// Self-checking bench for the quad system interface multiplexer
`timescale 1ns/1ps
module test_qsm_sys_mux;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rd_data;
  logic lclk, sync, txd, txs, pin = 1'b0;
  logic [3:0][7:0] rx_byte = '0;
  logic [3:0][7:0] rx_sig = '0;
  logic [3:0][7:0] o_tx_byte, o_tx_sig_byte;
  logic [3:0] o_tx_valid, fclk = '0, sec = '0, rxclk = '0;
  logic o_rx_data_out, o_rx_sig_out, o_shared_port_out, o_shared_port_oe_n, o_sec_timer_in;
  logic o_rx_clk1, o_rx_sys_clk_oe_n, o_tx_sys_clk_oe_n, o_rx_route_clk_oe_n;
  logic [2:0] o_rx_clk_rest;
  logic [4:0] o_rx_slot, o_tx_slot;
  logic mfp = 1'b0;
  logic [7:0] v, r;
  logic [7:0] cv [4];
  logic act, e;
  int mismatches = 0;
  int cmp_count = 0;
  int vcnt = 0;

  qsm_sys_mux dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_rx_sys_clk(lclk),
    .i_rx_sync_pulse(sync), .i_tx_sys_clk(lclk), .i_tx_sync_pulse(sync),
    .i_tx_multiframe_sync(sync ^ !mfp), .i_tx_data_in(txd), .i_tx_sig_in(txs),
    .i_rx_byte(rx_byte),
    .i_rx_sig_byte(rx_sig), .o_rx_slot(o_rx_slot), .o_rx_data_out(o_rx_data_out),
    .o_rx_sig_out(o_rx_sig_out), .o_tx_byte(o_tx_byte), .o_tx_sig_byte(o_tx_sig_byte),
    .o_tx_valid(o_tx_valid), .o_tx_slot(o_tx_slot), .i_ch_frame_clk(fclk), .i_ch_sec_timer(sec),
    .i_shared_port_in(pin), .o_shared_port_out(o_shared_port_out),
    .o_shared_port_oe_n(o_shared_port_oe_n), .o_sec_timer_in(o_sec_timer_in),
    .i_ch_rx_clk(rxclk), .o_rx_clk1(o_rx_clk1), .o_rx_clk_rest(o_rx_clk_rest),
    .o_rx_sys_clk_oe_n(o_rx_sys_clk_oe_n), .o_tx_sys_clk_oe_n(o_tx_sys_clk_oe_n),
    .o_rx_route_clk_oe_n(o_rx_route_clk_oe_n));

  qsm_far_end far (.o_link_clk(lclk), .o_sync(sync), .o_data(txd), .o_sig(txs),
    .i_data(o_rx_data_out), .i_sig(o_rx_sig_out));

  // 50 MHz clock
  initial begin
    forever #10 i_clk = ~i_clk;
  end

  // Count completed transmit bytes on all channels
  always @(negedge i_clk) vcnt += $countones(o_tx_valid);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rd_data;
  endtask

  // Reference model: stream bit at position k, MSB of each byte first
  function automatic logic sbit(input logic [3:0][7:0] b, input int k, input logic interleave_select);
    int ch = interleave_select ? k % 4 : k / 8;
    int bt = interleave_select ? k / 4 : k % 8;
    return b[ch][7 - bt];
  endfunction

  // One multiplexed time slot both ways at 8.192 Mbit/s; mf starts transmit on multiframe sync
  task automatic run_frame(input logic interleave_select, input logic mf, input logic pol);
    logic [3:0][7:0] tb, ts;
    logic [31:0] d, s, rdb, rsb;
    int v0;
    tb = $urandom;
    ts = $urandom;
    rx_byte <= $urandom;
    rx_sig <= $urandom;
    mfp <= pol;
    wr(8'h84, {4'h0, pol, 3'h0});
    wr(8'h86, {2'h0, mf, interleave_select, 4'h6});
    for (int k = 0; k < 32; k++) begin
      d[k] = sbit(tb, k, interleave_select);
      s[k] = sbit(ts, k, interleave_select);
    end
    v0 = vcnt;
    @(posedge i_clk);
    far.frame(d, s, rdb, rsb);
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 32; k++) begin
      chk(rdb[k], sbit(rx_byte, k, interleave_select));
      chk(rsb[k], sbit(rx_sig, k, interleave_select));
    end
    chk(o_tx_byte, tb);
    chk(o_tx_sig_byte, ts);
    chk(vcnt - v0, 4);
    // One slot of four framers done: stream stands at slot 1
    chk(o_rx_slot, 5'h01);
    chk(o_tx_slot, 5'h00);
    rd(8'h94, r);
    chk(r, 8'h07);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    final_report();
  end

  initial begin
    void'($urandom(32'h02611B52));
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({o_shared_port_oe_n, o_rx_sys_clk_oe_n, o_tx_sys_clk_oe_n, o_rx_route_clk_oe_n}, 4'hF);
    rd(8'h85, r);
    chk(r, 8'h00);
    wr(8'h85, 8'hFF);
    rd(8'h85, r);
    chk(r, 8'h7F);
    rd(8'h20, r);
    chk(r, 8'h00);
    // Direction bits, each state of each bit
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h05 : (i == 1) ? 8'hFA : 8'($urandom);
      wr(8'h84, v);
      rd(8'h84, r);
      chk(r, v & 8'h0F);
      chk({o_tx_sys_clk_oe_n, o_rx_sys_clk_oe_n}, v[2:1] ^ 2'h3);
      chk(o_rx_route_clk_oe_n, !v[0]);
    end
    // Shared port modes, sources and first receive clock routing
    for (int i = 0; i < 24; i++) begin
      for (int c = 0; c < 4; c++) begin
        cv[c] = {2'h0, 3'($urandom), 3'(c)};
        wr(8'h90 + 8'(c), cv[c]);
      end
      v = {2'h0, 2'(i), 4'($urandom)};
      fclk <= $urandom;
      sec <= $urandom;
      rxclk <= $urandom;
      pin <= $urandom;
      wr(8'h85, v);
      repeat (6) @(posedge i_clk);
      #1;
      chk(o_rx_clk1, rxclk[v[1:0]]);
      chk(o_rx_clk_rest, rxclk[3:1]);
      act = cv[v[3:2]][3] | cv[v[3:2]][5];
      e = (v[5:4] == 2'h1) ? sec[v[3:2]] : fclk[v[3:2]] & act;
      e = (v[5:4] == 2'h3) ? ~e : e;
      chk(o_shared_port_oe_n, v[5:4] == 2'h0);
      chk(o_shared_port_out, (v[5:4] == 2'h0) ? 1'b0 : e);
      chk(o_sec_timer_in, (v[5:4] == 2'h0) ? pin : 1'b0);
    end
    wr(8'h85, 8'h40);
    run_frame(1'b0, 1'b0, 1'b0);
    run_frame(1'b1, 1'b1, 1'b0);
    run_frame(1'b0, 1'b1, 1'b1);
    final_report();
  end
endmodule
